// [hw/cmc_consts.svh]
// Constants for the charger mode control block: field layouts, reset values, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMC_ADDR_W 4
`define CMC_OFS_CTRL_A 4'h0
`define CMC_OFS_CTRL_B 4'h1
`define CMC_OFS_CTRL_C 4'h2
`define CMC_OFS_PPATH 4'h3
`define CMC_OFS_STATUS 4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMC_A_BIAS 4
`define CMC_A_FAST_HI 3
`define CMC_A_FAST_LO 2
`define CMC_A_TERMDIS 1
`define CMC_A_SUSP 0
`define CMC_B_PTHR 6
`define CMC_B_BYP 5
`define CMC_B_VREG_HI 3
`define CMC_B_VREG_LO 2
`define CMC_B_EN_HI 1
`define CMC_C_EN_LO 7
`define CMC_C_TERM_HI 3
`define CMC_C_TERM_LO 2
`define CMC_C_PRE_HI 1
`define CMC_C_PRE_LO 0
`define CMC_P_RANGE 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMC_RST_CTRL_A 8'h0C
`define CMC_RST_CTRL_B 8'h00
`define CMC_RST_CTRL_C 8'h00
`define CMC_RST_PPATH 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CMC_CLK_MHZ 250
`define CMC_DGL_MS 25
`define CMC_DGL_CYC (`CMC_DGL_MS * 1000 * `CMC_CLK_MHZ)
`define CMC_CNT_W 24

`endif

// [hw/cmc_pkg.sv]
// Types shared by the charger mode control block.
// Assumes the constants header is on the include path.
`include "cmc_consts.svh"

package cmc_pkg;

    typedef enum logic [1:0] {CMC_OFF, CMC_ON, CMC_SUSPEND} cmc_mode_t;

    typedef enum logic [1:0] {CMC_ST_PRE, CMC_ST_DONE, CMC_ST_FAST, CMC_ST_SUSP} cmc_state_t;

    // Analog conditions reported to the logic; the top module synchronises them in two stages.
    typedef struct packed {
        logic input_power;
        logic preregulator_on;
        logic prereg_is_charger;
        logic thermal_shutdown;
        logic sleep;
        logic pack_temp_fault;
        logic below_precharge;
        logic below_recharge;
        logic volt_regulation;
        logic below_term;
    } cmc_sense_t;

    // Controls driven to the analog charger.
    typedef struct packed {
        logic charger_run;
        logic fast_phase;
        logic bias_on;
        logic ldo_mode;
        logic timer_reset;
        logic timer_hold;
        logic discharge_allow;
        logic [1:0] precharge_scale;
        logic precharge_threshold_sel;
        logic [1:0] fastcharge_scale;
        logic [2:0] regulation_voltage_sel;
        logic [1:0] term_scale;
    } cmc_ctrl_t;

endpackage

// [hw/cmc_top.sv]
// Charger mode control: mode selection, phase, termination and recharge deglitch.
// Assumes analog sense pins come from other domains and a register port on clk_sys_i.
//
// How it works
// (R1) Bias on if requested or charger active.
// (R2) Host disables charger after pack removal.
// (R3) Pre-charge below threshold, else fast charge.
// (R4) Pre-charge scale field and threshold select.
// (R5) Fast-charge scale field picks four fractions.
// (R6) Fast scale codes 00..11, reset 11.
// (R7) Regulation voltage from field plus range.
// (R8) LDO mode when termdis and bypass set.
// (R9) LDO mode: no termination, timers reset.
// (R10) Host sets prereg voltage before LDO.
// (R11) LDO mode keeps current loops and phases.
// (R12) Timers reset whenever mode is off.
// (R13) Enable table by enable bits and sleep.
// (R14) Latch faults, force off, clear on cycle.
// (R15) Off in lockout, no power, shutdown.
// (R16) On, off or suspend by priority.
// (R17) Suspend, or temp fault with bypass clear, freezes timers.
// (R18) Termination after deglitch in regulation.
// (R19) Termination flag ignores termination disable.
// (R20) Enabled termination ends cycle, charger off.
// (R21) Termination scale field scales threshold.
// (R22) Done status only with termination.
// (R23) New cycle: recharge, enable rise, power.
// (R24) Pack insertion no restart after termination.
// (R25) Deglitch counters restart when condition drops.
`timescale 1ns/1ps
`include "cmc_consts.svh"

module cmc_top
    import cmc_pkg::*;
#(
    parameter logic [`CMC_CNT_W-1:0] DGL_CYCLES = `CMC_CNT_W'(`CMC_DGL_CYC)
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [`CMC_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire cmc_sense_t sense_i,
    input wire logic timer_fault_i,
    input wire logic pack_insert_i,
    output cmc_ctrl_t ctrl_o,
    output cmc_mode_t mode_o
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Timer fault and pack insertion come from the analog/timer side too.
    cmc_sense_t sense_meta_ff;
    cmc_sense_t sense_ff;
    logic [1:0] ev_meta_ff;
    logic [1:0] ev_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sense_meta_ff <= '0;
            sense_ff <= '0;
            ev_meta_ff <= 2'h0;
            ev_ff <= 2'h0;
        end
        else
        begin
            sense_meta_ff <= sense_i;
            sense_ff <= sense_meta_ff;
            ev_meta_ff <= {pack_insert_i, timer_fault_i};
            ev_ff <= ev_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] ctrl_c_ff;
    logic [7:0] ppath_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] status;
    logic term_flag_ff;
    logic term_latch_ff;
    logic fault_latch_ff;
    cmc_mode_t mode_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_a_ff <= `CMC_RST_CTRL_A; // see (R6)
            ctrl_b_ff <= `CMC_RST_CTRL_B;
            ctrl_c_ff <= `CMC_RST_CTRL_C;
            ppath_ff <= `CMC_RST_PPATH;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `CMC_OFS_CTRL_A: ctrl_a_ff <= wdata_i;
                `CMC_OFS_CTRL_B: ctrl_b_ff <= wdata_i;
                `CMC_OFS_CTRL_C: ctrl_c_ff <= wdata_i;
                `CMC_OFS_PPATH: ppath_ff <= wdata_i;
                default: ;
            endcase
        end
    end

    cmc_state_t chg_state;

    always_comb
    begin
        if (mode_ff == CMC_SUSPEND || fault_latch_ff)
            chg_state = CMC_ST_SUSP;
        else if (term_latch_ff)
            chg_state = CMC_ST_DONE; // see (R22)
        else if (ctrl_o.fast_phase)
            chg_state = CMC_ST_FAST;
        else
            chg_state = CMC_ST_PRE;
    end

    always_comb
    begin
        status = {2'h0, mode_ff, fault_latch_ff, chg_state, term_flag_ff};
        case (addr_i)
            `CMC_OFS_CTRL_A: nxt_rdata = ctrl_a_ff;
            `CMC_OFS_CTRL_B: nxt_rdata = ctrl_b_ff;
            `CMC_OFS_CTRL_C: nxt_rdata = ctrl_c_ff;
            `CMC_OFS_PPATH: nxt_rdata = ppath_ff;
            `CMC_OFS_STATUS: nxt_rdata = status;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data is held at zero outside the answer cycle.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= nxt_rdata;
        else
            rdata_o <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Mode qualification
    // ----------------------------------------------------------------
    logic termdis;
    logic bypass;
    logic ldo_mode;
    logic en_hi;
    logic en_lo;
    logic enabled;
    logic qualified;
    logic temp_fault;
    logic term_kill;
    cmc_mode_t nxt_mode;

    assign termdis = ctrl_a_ff[`CMC_A_TERMDIS];
    assign bypass = ctrl_b_ff[`CMC_B_BYP];
    assign ldo_mode = termdis && bypass; // see (R8)
    assign en_hi = ctrl_b_ff[`CMC_B_EN_HI];
    assign en_lo = ctrl_c_ff[`CMC_C_EN_LO];
    // Host must clear the upper enable bit on pack removal; the logic obeys it. see (R2)
    assign enabled = sense_ff.sleep ? en_hi : (en_hi && en_lo); // see (R13)
    assign qualified = sense_ff.input_power && !sense_ff.thermal_shutdown &&
                       (sense_ff.preregulator_on || !sense_ff.prereg_is_charger) &&
                       enabled; // see (R15)
    assign temp_fault = sense_ff.pack_temp_fault && !bypass;
    assign term_kill = term_latch_ff && !termdis && !ldo_mode; // see (R20)

    always_comb
    begin
        if (!qualified)
            nxt_mode = CMC_OFF;
        else if (fault_latch_ff || term_kill)
            nxt_mode = CMC_OFF; // see (R14)
        else if (ctrl_a_ff[`CMC_A_SUSP] || temp_fault)
            nxt_mode = CMC_SUSPEND; // see (R17)
        else
            nxt_mode = CMC_ON; // see (R16)
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mode_ff <= CMC_OFF;
        else
            mode_ff <= nxt_mode;
    end

    // ----------------------------------------------------------------
    // Deglitch counters
    // ----------------------------------------------------------------
    logic term_cond;
    logic rch_cond;
    logic [`CMC_CNT_W-1:0] term_cnt_ff;
    logic [`CMC_CNT_W-1:0] rch_cnt_ff;
    logic term_seen;
    logic rch_seen;

    assign term_cond = sense_ff.volt_regulation && sense_ff.below_term && mode_ff == CMC_ON;
    assign rch_cond = sense_ff.below_recharge;
    assign term_seen = term_cond && term_cnt_ff == DGL_CYCLES;
    assign rch_seen = rch_cond && rch_cnt_ff == DGL_CYCLES;

    // Counters saturate so a lasting condition does not re-trigger.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            term_cnt_ff <= '0;
            rch_cnt_ff <= '0;
        end
        else
        begin
            if (!term_cond)
                term_cnt_ff <= '0; // see (R25)
            else if (term_cnt_ff <= DGL_CYCLES)
                term_cnt_ff <= term_cnt_ff + `CMC_CNT_W'(1); // see (R18)
            if (!rch_cond)
                rch_cnt_ff <= '0; // see (R25)
            else if (rch_cnt_ff <= DGL_CYCLES)
                rch_cnt_ff <= rch_cnt_ff + `CMC_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // New cycle detection and latches
    // ----------------------------------------------------------------
    logic en_hi_d_ff;
    logic pwr_d_ff;
    logic new_cycle;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            en_hi_d_ff <= 1'b0;
            pwr_d_ff <= 1'b0;
        end
        else
        begin
            en_hi_d_ff <= en_hi;
            pwr_d_ff <= sense_ff.input_power;
        end
    end

    // Pack insertion is deliberately absent from the restart terms. see (R24)
    assign new_cycle = rch_seen ||
                       (en_hi && !en_hi_d_ff) ||
                       (sense_ff.input_power && !pwr_d_ff); // see (R23)

    // An event in the restart cycle wins, so it is never lost.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            term_flag_ff <= 1'b0;
            term_latch_ff <= 1'b0;
            fault_latch_ff <= 1'b0;
        end
        else
        begin
            if (term_seen)
                term_flag_ff <= 1'b1; // see (R19)
            else if (new_cycle)
                term_flag_ff <= 1'b0;
            if (term_seen && !ldo_mode)
                term_latch_ff <= 1'b1; // see (R9)
            else if (new_cycle)
                term_latch_ff <= 1'b0; // see (R14)
            if (ev_ff[0] && !ldo_mode)
                fault_latch_ff <= 1'b1;
            else if (new_cycle || ldo_mode)
                fault_latch_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Analog controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_o <= '0;
            mode_o <= CMC_OFF;
        end
        else
        begin
            mode_o <= mode_ff;
            ctrl_o.charger_run <= mode_ff == CMC_ON; // see (R11)
            ctrl_o.fast_phase <= !sense_ff.below_precharge; // see (R3)
            ctrl_o.bias_on <= ctrl_a_ff[`CMC_A_BIAS] || mode_ff != CMC_OFF; // see (R1)
            ctrl_o.ldo_mode <= ldo_mode;
            ctrl_o.timer_reset <= mode_ff == CMC_OFF || ldo_mode; // see (R12)
            ctrl_o.timer_hold <= mode_ff == CMC_SUSPEND; // see (R17)
            ctrl_o.discharge_allow <= !ldo_mode; // see (R9)
            ctrl_o.precharge_scale <= ctrl_c_ff[`CMC_C_PRE_HI:`CMC_C_PRE_LO]; // see (R4)
            ctrl_o.precharge_threshold_sel <= ctrl_b_ff[`CMC_B_PTHR];
            ctrl_o.fastcharge_scale <= ctrl_a_ff[`CMC_A_FAST_HI:`CMC_A_FAST_LO]; // see (R5)
            ctrl_o.regulation_voltage_sel <= {ppath_ff[`CMC_P_RANGE],
                ctrl_b_ff[`CMC_B_VREG_HI:`CMC_B_VREG_LO]}; // see (R7)
            ctrl_o.term_scale <= ctrl_c_ff[`CMC_C_TERM_HI:`CMC_C_TERM_LO]; // see (R21)
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_bias;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode_ff != CMC_OFF) |=> ctrl_o.bias_on;
    endproperty
    a_bias: assert property (p_bias) else $error("bias off while active"); // see (R1)

    property p_ldo_timers;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ldo_mode |=> (ctrl_o.timer_reset && !ctrl_o.discharge_allow);
    endproperty
    a_ldo_timers: assert property (p_ldo_timers) else $error("ldo timers"); // see (R9)

    property p_off_reset;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode_ff == CMC_OFF) |=> ctrl_o.timer_reset;
    endproperty
    a_off_reset: assert property (p_off_reset) else $error("timers not reset"); // see (R12)

    property p_unqual_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !qualified |=> (mode_ff == CMC_OFF) ##1 (mode_o == CMC_OFF);
    endproperty
    a_unqual_off: assert property (p_unqual_off) else $error("not off"); // see (R15)

    property p_fault_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        fault_latch_ff |=> (mode_ff == CMC_OFF);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault not off"); // see (R14)

    property p_susp;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (qualified && !fault_latch_ff && !term_kill && ctrl_a_ff[`CMC_A_SUSP])
        |=> (mode_ff == CMC_SUSPEND) ##1 ctrl_o.timer_hold;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend missing"); // see (R17)

    property p_term_dgl;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(term_flag_ff) |-> $past(term_cnt_ff) == DGL_CYCLES;
    endproperty
    a_term_dgl: assert property (p_term_dgl) else $error("early termination"); // see (R18)

    property p_done;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (chg_state == CMC_ST_DONE) |-> term_latch_ff;
    endproperty
    a_done: assert property (p_done) else $error("done without term"); // see (R22)

    property p_restart;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (en_hi && !en_hi_d_ff && !term_seen) |=> !term_latch_ff;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // see (R23)

    property p_insert_no_restart;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (ev_ff[1] && term_latch_ff && !new_cycle) |=> term_latch_ff;
    endproperty
    a_insert_no_restart: assert property (p_insert_no_restart) else $error("insert restart"); // see (R24)

endmodule

// [test/cmc_top_tb.sv]
// Self-checking bench for the charger mode control block.
// Assumes the constants header is on the include path and a 20-cycle deglitch.
`timescale 1ns/1ps
`include "cmc_consts.svh"

module cmc_top_tb;
import cmc_pkg::*;

localparam logic [`CMC_CNT_W-1:0] DGL = `CMC_CNT_W'(20);
logic clk_sys_i;
logic rst_n_i;
logic wr_i;
logic rd_i;
logic timer_fault_i;
logic pack_insert_i;
logic [`CMC_ADDR_W-1:0] addr_i;
logic [7:0] wdata_i;
logic [7:0] rdata_o;
logic [7:0] rd_val;
cmc_sense_t sense_i;
cmc_ctrl_t ctrl_o;
cmc_mode_t mode_o;
int n_errors;
int check_count;

cmc_top #(.DGL_CYCLES(DGL)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sense_i(sense_i),
    .timer_fault_i(timer_fault_i), .pack_insert_i(pack_insert_i), .ctrl_o(ctrl_o),
    .mode_o(mode_o));

// ----------------------------------------------------------------
// Bus and compare helpers
// ----------------------------------------------------------------
task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
        n_errors++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
endtask

task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    // Read data stand only in the cycle after the strobe; take them at its closing edge.
    @(posedge clk_sys_i);
    rd_val = rdata_o;
endtask

// Sense inputs cross two sync stages plus the mode and output registers.
task automatic settle();
    repeat (6) @(posedge clk_sys_i);
endtask

task automatic hold_cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
endtask

task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask

// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task automatic t_reset();
    rd(`CMC_OFS_CTRL_A);
    chk(rd_val, 8'h0C);
    rd(`CMC_OFS_CTRL_C);
    chk(rd_val, 8'h00);
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    chk({7'h00, ctrl_o.timer_reset}, 8'h01);
    rd(4'h7);
    chk(rd_val, 8'h00);
    wr(`CMC_OFS_STATUS, 8'hFF);
    rd(`CMC_OFS_STATUS);
    chk(rd_val & 8'h09, 8'h00);
endtask

task automatic t_fields();
    for (int i = 0; i < 4; i++)
    begin
        wr(`CMC_OFS_CTRL_A, {4'h0, 2'(i), 2'b00});
        wr(`CMC_OFS_CTRL_C, {4'h0, 2'(3 - i), 2'(i)});
        wr(`CMC_OFS_CTRL_B, {4'h0, 2'(i), 2'b00});
        wr(`CMC_OFS_PPATH, {3'h0, 1'(i), 4'h0});
        settle();
        chk({6'h00, ctrl_o.fastcharge_scale}, {6'h00, 2'(i)});
        chk({6'h00, ctrl_o.precharge_scale}, {6'h00, 2'(i)});
        chk({6'h00, ctrl_o.term_scale}, {6'h00, 2'(3 - i)});
        chk({5'h00, ctrl_o.regulation_voltage_sel}, {5'h00, 1'(i), 2'(i)});
    end
    wr(`CMC_OFS_CTRL_B, 8'h40);
    wr(`CMC_OFS_CTRL_A, 8'h10);
    settle();
    chk({7'h00, ctrl_o.precharge_threshold_sel}, 8'h01);
    chk({7'h00, ctrl_o.bias_on}, 8'h01);
    wr(`CMC_OFS_CTRL_A, 8'h00);
    settle();
    chk({7'h00, ctrl_o.bias_on}, 8'h00);
endtask

task automatic t_enable();
    @(posedge clk_sys_i);
    sense_i.input_power <= 1'b1;
    sense_i.preregulator_on <= 1'b1;
    sense_i.prereg_is_charger <= 1'b1;
    wr(`CMC_OFS_CTRL_B, 8'h02);
    wr(`CMC_OFS_CTRL_C, 8'h00);
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    sense_i.sleep <= 1'b1;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    sense_i.sleep <= 1'b0;
    wr(`CMC_OFS_CTRL_C, 8'h80);
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    chk({7'h00, ctrl_o.bias_on}, 8'h01);
    chk({7'h00, ctrl_o.charger_run}, 8'h01);
    sense_i.preregulator_on <= 1'b0;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    chk({7'h00, ctrl_o.timer_reset}, 8'h01);
    // Once the pre-regulator has another role, its state no longer gates the charger.
    sense_i.prereg_is_charger <= 1'b0;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    sense_i.preregulator_on <= 1'b1;
    sense_i.prereg_is_charger <= 1'b1;
    sense_i.thermal_shutdown <= 1'b1;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    sense_i.thermal_shutdown <= 1'b0;
    sense_i.below_precharge <= 1'b1;
    settle();
    chk({7'h00, ctrl_o.fast_phase}, 8'h00);
    sense_i.below_precharge <= 1'b0;
    settle();
    chk({7'h00, ctrl_o.fast_phase}, 8'h01);
endtask

task automatic t_suspend();
    wr(`CMC_OFS_CTRL_A, 8'h01);
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_SUSPEND});
    chk({7'h00, ctrl_o.timer_hold}, 8'h01);
    wr(`CMC_OFS_CTRL_A, 8'h00);
    sense_i.pack_temp_fault <= 1'b1;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_SUSPEND});
    wr(`CMC_OFS_CTRL_B, 8'h22);
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    sense_i.pack_temp_fault <= 1'b0;
    // The pre-regulator voltage lives outside this block; the bench takes it as set.
    wr(`CMC_OFS_CTRL_A, 8'h02);
    settle();
    chk({7'h00, ctrl_o.ldo_mode}, 8'h01);
    chk({7'h00, ctrl_o.timer_reset}, 8'h01);
    chk({7'h00, ctrl_o.discharge_allow}, 8'h00);
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    wr(`CMC_OFS_CTRL_B, 8'h02);
    settle();
    chk({7'h00, ctrl_o.ldo_mode}, 8'h00);
endtask

task automatic t_term();
    // Termination disable is still set here, so the flag and latch may move but the charger stays on.
    sense_i.volt_regulation <= 1'b1;
    sense_i.below_term <= 1'b1;
    hold_cycles(15);
    sense_i.below_term <= 1'b0;
    hold_cycles(2);
    sense_i.below_term <= 1'b1;
    hold_cycles(15);
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[0]}, 8'h00);
    hold_cycles(20);
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[0]}, 8'h01);
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    sense_i.below_term <= 1'b0;
    wr(`CMC_OFS_CTRL_B, 8'h00);
    wr(`CMC_OFS_CTRL_B, 8'h02);
    wr(`CMC_OFS_CTRL_A, 8'h00);
    settle();
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[0]}, 8'h00);
    chk({6'h00, rd_val[2:1]}, {6'h00, CMC_ST_FAST});
    sense_i.below_term <= 1'b1;
    hold_cycles(35);
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[0]}, 8'h01);
    chk({6'h00, rd_val[2:1]}, {6'h00, CMC_ST_DONE});
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    sense_i.below_term <= 1'b0;
    sense_i.volt_regulation <= 1'b0;
    pack_insert_i <= 1'b1;
    hold_cycles(3);
    pack_insert_i <= 1'b0;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    sense_i.below_recharge <= 1'b1;
    hold_cycles(35);
    sense_i.below_recharge <= 1'b0;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
endtask

task automatic t_fault();
    timer_fault_i <= 1'b1;
    hold_cycles(3);
    timer_fault_i <= 1'b0;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[3]}, 8'h01);
    chk({7'h00, ctrl_o.timer_reset}, 8'h01);
    sense_i.input_power <= 1'b0;
    settle();
    sense_i.input_power <= 1'b1;
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_ON});
    rd(`CMC_OFS_STATUS);
    chk({7'h00, rd_val[3]}, 8'h00);
    // Pack removal reported: the host drops the upper enable bit.
    wr(`CMC_OFS_CTRL_B, 8'h00);
    settle();
    chk({6'h00, mode_o}, {6'h00, CMC_OFF});
endtask

// ----------------------------------------------------------------
// Clock, reset, sequence and watchdog
// ----------------------------------------------------------------
initial
begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
end

initial
begin
    n_errors = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = 8'h00;
    sense_i = '0;
    timer_fault_i = 1'b0;
    pack_insert_i = 1'b0;
    hold_cycles(10);
    rst_n_i <= 1'b1;
    t_reset();
    t_fields();
    t_enable();
    t_suspend();
    t_term();
    t_fault();
    results();
end

// The full sequence needs well under 2000 cycles.
initial
begin
    #40us;
    n_errors++;
    results();
end

endmodule
